// ### hw/upconv_regs_pkg.sv
`default_nettype none
package upconv_regs_pkg;
   localparam logic [4:0] ADDR_SYNC = 5'h0A;
   localparam logic [4:0] ADDR_SLOT_FIRST = 5'h0E;
   localparam logic [4:0] ADDR_SLOT_LAST = 5'h15;
   localparam logic [4:0] ADDR_RAM = 5'h16;
   localparam logic [4:0] ADDR_PIN_DIR = 5'h18;
   localparam logic [4:0] ADDR_PIN_DATA = 5'h19;
   localparam logic [31:0] SYNC_RESET = 32'h00000000;
   localparam logic [31:0] SYNC_WMASK = 32'hFEFCF8F8;
   localparam int SYNC_VAL_LSB = 28;
   localparam int SYNC_RX_EN_BIT = 27;
   localparam int SYNC_GEN_EN_BIT = 26;
   localparam int SYNC_GEN_POL_BIT = 25;
   localparam int SYNC_PRESET_LSB = 18;
   localparam int SYNC_GEN_DLY_LSB = 11;
   localparam int SYNC_RX_DLY_LSB = 3;
   localparam int TONE_AMP_LSB = 48;
   localparam int PHASE_LSB = 32;
   localparam int FTW_LSB = 0;
   localparam int QD_RATE_LSB = 58;
   localparam int QD_INVERT_BIT = 57;
   localparam int QD_BYPASS_BIT = 56;
   localparam int QD_SCALE_LSB = 48;
   localparam logic [63:0] SLOT_RESET = 64'h0000000000000000;
   localparam logic [63:0] TONE_WMASK = 64'h3FFFFFFFFFFFFFFF;
   localparam logic [63:0] QD_WMASK = 64'hFFFFFFFFFFFFFFFF;
   localparam logic [1:0] MODE_QUADRATURE_UPCONVERTER_MODE = 2'h0;
   localparam logic [1:0] MODE_INTERP = 2'h2;
   localparam logic [1:0] MODE_TONE = 2'h3;
   localparam logic [15:0] PIN_DIR_RESET = 16'h0000;
   localparam logic [15:0] PIN_DATA_RESET = 16'h0000;
   localparam logic [9:0] RAM_ADDR_RESET = 10'h000;
   localparam logic [31:0] RAM_WORD_RESET = 32'h00000000;
   localparam logic [5:0] SYNC_STATE_RESET = 6'h00;

   typedef enum logic {RAM_IDLE, RAM_LOADING} ram_load_state_type;

   typedef struct packed {
      logic [3:0] validation_delay;
      logic rx_enable;
      logic gen_enable;
      logic gen_falling_edge;
      logic [5:0] preset_state;
      logic [4:0] gen_delay;
      logic [4:0] rx_delay;
   } sync_fields_type;

   typedef struct packed {
      logic [31:0] tuning_word;
      logic [15:0] phase_offset;
      logic [13:0] tone_amplitude;
      logic [5:0] interp_rate;
      logic spectral_invert;
      logic inverse_filter_bypass;
      logic [7:0] output_scale;
   } profile_out_type;

   typedef struct packed {
      logic [3:0] stage1;
      logic [3:0] stage2;
   } pin_sync_state_type;

   typedef struct packed {
      logic [15:0] stage1;
      logic [15:0] stage2;
      logic [15:0] out_latch;
      logic [15:0] oe;
      logic [15:0] read_value;
   } gpio_state_type;
endpackage : upconv_regs_pkg
`default_nettype wire

// ### hw/pin_sync.sv
`default_nettype none
module pin_sync
   import upconv_regs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [3:0] i_pins,
   output logic [3:0] o_pins
);
   pin_sync_state_type s;
   pin_sync_state_type next_s;

   always_comb
   begin
      next_s = s;
      next_s.stage1 = i_pins;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_pins = s.stage2;
endmodule : pin_sync
`default_nettype wire

// ### hw/gpio_port.sv
`default_nettype none
module gpio_port
   import upconv_regs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [15:0] i_pins,
   input wire logic [15:0] i_dir,
   input wire logic i_write,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_out,
   output logic [15:0] o_oe,
   output logic [15:0] o_read_value
);
   gpio_state_type s;
   gpio_state_type next_s;

   always_comb
   begin
      next_s = s;
      next_s.stage1 = i_pins;
      next_s.stage2 = s.stage1;
      next_s.oe = i_dir;
      // only bits configured as outputs take the written value
      if (i_write)
         next_s.out_latch = (i_wdata & i_dir) | (s.out_latch & ~i_dir);
      next_s.read_value = (s.out_latch & i_dir) | (s.stage2 & ~i_dir);
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s <= '0;
         s.out_latch <= PIN_DATA_RESET;
         s.oe <= PIN_DIR_RESET;
      end
      else
         s <= next_s;
   end

   assign o_out = s.out_latch;
   assign o_oe = s.oe;
   assign o_read_value = s.read_value;

   a_input_bits_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_write |=> ((o_out ^ $past(o_out)) & ~$past(i_dir)) == 16'h0000)
      else $error("gpio input bit changed by a write");
endmodule : gpio_port
`default_nettype wire

// ### hw/sync_profile_ram_gpio_regs.sv
`default_nettype none
module sync_profile_ram_gpio_regs
   import upconv_regs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [4:0] i_reg_addr,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   input wire logic [63:0] i_reg_wdata,
   output logic [63:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic [1:0] i_operating_mode,
   input wire logic i_profile_select_bit2,
   input wire logic i_profile_select_bit1,
   input wire logic i_profile_select_bit0,
   input wire logic i_sync_pulse,
   output sync_fields_type o_sync,
   output logic [5:0] o_sync_state,
   output profile_out_type o_profile,
   input wire logic [9:0] i_ram_start,
   input wire logic [9:0] i_ram_end,
   input wire logic i_ram_restart,
   output logic o_ram_wr_strobe,
   output logic [9:0] o_ram_wr_addr,
   output logic [31:0] o_ram_wr_data,
   input wire logic [15:0] i_gpio_pins,
   output logic [15:0] o_gpio_out,
   output logic [15:0] o_gpio_oe
);
   typedef struct packed {
      logic [31:0] sync_ctrl;
      logic [7:0][63:0] slot;
      logic [15:0] pin_dir;
      logic [31:0] ram_word;
      logic [9:0] ram_addr;
      ram_load_state_type ram_state;
      logic ram_strobe;
      logic [5:0] sync_state;
      logic pulse_last;
      logic [63:0] rdata;
      logic rvalid;
      profile_out_type prof;
   } core_state_type;

   core_state_type s;
   core_state_type next_s;
   logic [3:0] synced;
   logic [2:0] select;
   logic pulse_now;
   logic pulse_edge;
   logic [63:0] active_slot;
   logic [63:0] slot_mask;
   logic [2:0] slot_index;
   logic is_slot;
   logic [15:0] gpio_read;
   logic gpio_write;

   function automatic logic [63:0] layout_mask(input logic [1:0] mode);
      // open bits differ between layouts
      if (mode == MODE_TONE)
         return TONE_WMASK;
      else
         return QD_WMASK;
   endfunction : layout_mask

   function automatic sync_fields_type decode_sync(input logic [31:0] r);
      sync_fields_type f;
      f.validation_delay = r[SYNC_VAL_LSB +: 4];
      f.rx_enable = r[SYNC_RX_EN_BIT];
      f.gen_enable = r[SYNC_GEN_EN_BIT];
      f.gen_falling_edge = r[SYNC_GEN_POL_BIT];
      f.preset_state = r[SYNC_PRESET_LSB +: 6];
      f.gen_delay = r[SYNC_GEN_DLY_LSB +: 5];
      f.rx_delay = r[SYNC_RX_DLY_LSB +: 5];
      return f;
   endfunction : decode_sync

   // profile pins and the sync pulse come from outside the clock domain
   pin_sync u_pin_sync
   (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_pins({i_sync_pulse, i_profile_select_bit2, i_profile_select_bit1,
         i_profile_select_bit0}),
      .o_pins(synced)
   );

   gpio_port u_gpio_port
   (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_pins(i_gpio_pins),
      .i_dir(s.pin_dir),
      .i_write(gpio_write),
      .i_wdata(i_reg_wdata[15:0]),
      .o_out(o_gpio_out),
      .o_oe(o_gpio_oe),
      .o_read_value(gpio_read)
   );

   assign select = synced[2:0];
   assign pulse_now = synced[3];
   assign pulse_edge = pulse_now && !s.pulse_last;
   assign active_slot = s.slot[select];
   assign slot_mask = layout_mask(i_operating_mode);
   assign is_slot = (i_reg_addr >= ADDR_SLOT_FIRST) && (i_reg_addr <= ADDR_SLOT_LAST);
   assign slot_index = 3'(i_reg_addr - ADDR_SLOT_FIRST);
   assign gpio_write = i_reg_write && (i_reg_addr == ADDR_PIN_DATA);

   always_comb
   begin
      next_s = s;
      next_s.ram_strobe = 1'b0;
      next_s.rvalid = i_reg_read;
      next_s.pulse_last = pulse_now;

      if (i_reg_write)
      begin
         if (i_reg_addr == ADDR_SYNC)
            next_s.sync_ctrl = i_reg_wdata[31:0] & SYNC_WMASK;
         if (is_slot)
            next_s.slot[slot_index] = i_reg_wdata & slot_mask;
         if (i_reg_addr == ADDR_PIN_DIR)
            next_s.pin_dir = i_reg_wdata[15:0];
         if (i_reg_addr == ADDR_RAM)
         begin
            // the word count is the host's business; past the end we restart
            next_s.ram_word = i_reg_wdata[31:0];
            next_s.ram_strobe = 1'b1;
            next_s.ram_state = RAM_LOADING;
            case (s.ram_state)
               RAM_IDLE:
                  next_s.ram_addr = i_ram_start;
               RAM_LOADING:
               begin
                  if (s.ram_addr == i_ram_end)
                     next_s.ram_addr = i_ram_start;
                  else
                     next_s.ram_addr = s.ram_addr + 10'h001;
               end
               default:
                  next_s.ram_addr = i_ram_start;
            endcase
         end
      end
      // a changed segment starts the next load at its start address, unless ADDR_RAM is written in the same cycle
      if (i_ram_restart && !(i_reg_write && i_reg_addr == ADDR_RAM))
         next_s.ram_state = RAM_IDLE;

      next_s.rdata = 64'h0000000000000000;
      if (i_reg_read)
      begin
         if (i_reg_addr == ADDR_SYNC)
            next_s.rdata = {32'h00000000, s.sync_ctrl};
         else if (is_slot)
            next_s.rdata = s.slot[slot_index] & slot_mask;
         else if (i_reg_addr == ADDR_RAM)
            next_s.rdata = {32'h00000000, s.ram_word};
         else if (i_reg_addr == ADDR_PIN_DIR)
            next_s.rdata = {48'h000000000000, s.pin_dir};
         else if (i_reg_addr == ADDR_PIN_DATA)
            next_s.rdata = {48'h000000000000, gpio_read};
      end

      // preset wins over counting so a pulse realigns every chip at once
      if (pulse_edge && s.sync_ctrl[SYNC_RX_EN_BIT])
         next_s.sync_state = s.sync_ctrl[SYNC_PRESET_LSB +: 6];
      else if (s.sync_ctrl[SYNC_GEN_EN_BIT])
         next_s.sync_state = s.sync_state + 6'h01;

      next_s.prof = '0;
      case (i_operating_mode)
         MODE_TONE:
         begin
            next_s.prof.tuning_word = active_slot[FTW_LSB +: 32];
            next_s.prof.phase_offset = active_slot[PHASE_LSB +: 16];
            next_s.prof.tone_amplitude = active_slot[TONE_AMP_LSB +: 14];
         end
         MODE_INTERP:
         begin
            // the remaining fields stay zero so downstream never sees them
            next_s.prof.interp_rate = active_slot[QD_RATE_LSB +: 6];
            next_s.prof.inverse_filter_bypass = active_slot[QD_BYPASS_BIT];
            next_s.prof.output_scale = active_slot[QD_SCALE_LSB +: 8];
         end
         default:
         begin
            next_s.prof.tuning_word = active_slot[FTW_LSB +: 32];
            next_s.prof.phase_offset = active_slot[PHASE_LSB +: 16];
            next_s.prof.interp_rate = active_slot[QD_RATE_LSB +: 6];
            next_s.prof.spectral_invert = active_slot[QD_INVERT_BIT];
            next_s.prof.inverse_filter_bypass = active_slot[QD_BYPASS_BIT];
            next_s.prof.output_scale = active_slot[QD_SCALE_LSB +: 8];
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s <= '0;
         s.sync_ctrl <= SYNC_RESET;
         s.slot <= {8{SLOT_RESET}};
         s.pin_dir <= PIN_DIR_RESET;
         s.ram_word <= RAM_WORD_RESET;
         s.ram_addr <= RAM_ADDR_RESET;
         s.ram_state <= RAM_IDLE;
         s.sync_state <= SYNC_STATE_RESET;
      end
      else
         s <= next_s;
   end

   assign o_reg_rdata = s.rdata;
   assign o_reg_rvalid = s.rvalid;
   assign o_sync = decode_sync(s.sync_ctrl);
   assign o_sync_state = s.sync_state;
   assign o_profile = s.prof;
   assign o_ram_wr_strobe = s.ram_strobe;
   assign o_ram_wr_addr = s.ram_addr;
   assign o_ram_wr_data = s.ram_word;

   a_sync_read_open: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_read && i_reg_addr == ADDR_SYNC)
      |=> o_reg_rvalid && (o_reg_rdata & ~{32'h00000000, SYNC_WMASK}) == 64'h0)
      else $error("open sync bits read nonzero");

   a_sync_write_fields: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_SYNC)
      |=> o_sync.validation_delay == $past(i_reg_wdata[31:28])
      && o_sync.gen_delay == $past(i_reg_wdata[15:11])
      && o_sync.rx_delay == $past(i_reg_wdata[7:3]))
      else $error("sync delay fields not stored");

   a_rx_enable_set: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_SYNC) |=> o_sync.rx_enable == $past(i_reg_wdata[27]))
      else $error("receiver enable does not follow bit 27");

   a_gen_polarity: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_SYNC)
      |=> o_sync.gen_falling_edge == $past(i_reg_wdata[25])
      && o_sync.gen_enable == $past(i_reg_wdata[26]))
      else $error("generator polarity or enable wrong");

   a_preset_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (pulse_edge && o_sync.rx_enable) |=> o_sync_state == $past(o_sync.preset_state))
      else $error("preset not loaded on sync pulse");

   a_tone_layout: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_operating_mode == MODE_TONE)
      |=> o_profile.tuning_word == $past(active_slot[31:0])
      && o_profile.tone_amplitude == $past(active_slot[61:48]) && o_profile.output_scale == 8'h00)
      else $error("tone profile fields wrong");

   a_interp_ignored: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_operating_mode == MODE_INTERP)
      |=> o_profile.tuning_word == 32'h0 && o_profile.phase_offset == 16'h0
      && !o_profile.spectral_invert && o_profile.output_scale == $past(active_slot[55:48]))
      else $error("interpolating mode used ignored fields");

   a_quadrature_upconverter_mode_bits: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_operating_mode == MODE_QUADRATURE_UPCONVERTER_MODE)
      |=> o_profile.spectral_invert == $past(active_slot[57])
      && o_profile.inverse_filter_bypass == $past(active_slot[56]))
      else $error("sign or bypass bit wrong");

   a_ram_word_out: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_RAM)
      |=> o_ram_wr_strobe && o_ram_wr_data == $past(i_reg_wdata[31:0]) ##1 !o_ram_wr_strobe
      || $past(i_reg_write && i_reg_addr == ADDR_RAM))
      else $error("ram word strobe or data wrong");

   a_ram_first_addr: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_RAM && s.ram_state == RAM_IDLE)
      |=> o_ram_wr_addr == $past(i_ram_start))
      else $error("first ram word not at start address");

   a_read_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_reg_read |=> o_reg_rvalid)
      else $error("read strobe not answered");

   a_rdata_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_reg_read |=> !o_reg_rvalid && o_reg_rdata == 64'h0)
      else $error("read data not zero without a read");

   a_slot_open_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_read && is_slot && i_operating_mode == MODE_TONE)
      |=> o_reg_rdata[63:62] == 2'h0)
      else $error("open tone profile bits read nonzero");

   a_slot_write_store: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && is_slot)
      |=> s.slot[$past(slot_index)] == ($past(i_reg_wdata) & $past(slot_mask)))
      else $error("profile slot write not stored");

   a_gen_count: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (o_sync.gen_enable && !(pulse_edge && o_sync.rx_enable))
      |=> o_sync_state == $past(o_sync_state) + 6'h01)
      else $error("generator state did not advance");

   a_sync_state_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (!o_sync.gen_enable && !(pulse_edge && o_sync.rx_enable))
      |=> $stable(o_sync_state))
      else $error("sync state moved while idle");

   a_ram_step: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_RAM && s.ram_state == RAM_LOADING
      && o_ram_wr_addr != i_ram_end) |=> o_ram_wr_addr == $past(o_ram_wr_addr) + 10'h001)
      else $error("ram address did not step");

   a_ram_wrap: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_RAM && s.ram_state == RAM_LOADING
      && o_ram_wr_addr == i_ram_end) |=> o_ram_wr_addr == $past(i_ram_start))
      else $error("ram address did not wrap to start");

   a_pin_dir_store: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_reg_write && i_reg_addr == ADDR_PIN_DIR) |=> s.pin_dir == $past(i_reg_wdata[15:0]))
      else $error("pin direction not stored");

   a_quadrature_upconverter_mode_fields: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_operating_mode == MODE_QUADRATURE_UPCONVERTER_MODE)
      |=> o_profile.tuning_word == $past(active_slot[31:0])
      && o_profile.interp_rate == $past(active_slot[63:58])
      && o_profile.output_scale == $past(active_slot[55:48])
      && o_profile.tone_amplitude == 14'h0)
      else $error("upconverter profile fields wrong");
endmodule : sync_profile_ram_gpio_regs
`default_nettype wire

// ### dv/host_model.sv
`default_nettype none
module host_model
   import upconv_regs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reg_rvalid,
   input wire logic [63:0] i_reg_rdata,
   output logic [4:0] o_reg_addr,
   output logic o_reg_write,
   output logic o_reg_read,
   output logic [63:0] o_reg_wdata,
   output logic [2:0] o_profile_pins,
   output logic o_sync_pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      o_reg_addr = 5'h00;
      o_reg_write = 1'b0;
      o_reg_read = 1'b0;
      o_reg_wdata = 64'h0000000000000000;
      o_profile_pins = 3'h0;
      o_sync_pulse = 1'b0;
   end
   // one-cycle strobe; the idle cycle after it keeps two strobes from merging
   task automatic reg_write(input logic [4:0] addr, input logic [63:0] data);
      @(posedge i_clock);
      #1;
      o_reg_addr = addr;
      o_reg_wdata = data;
      o_reg_write = 1'b1;
      @(posedge i_clock);
      #1;
      o_reg_write = 1'b0;
      o_reg_wdata = ~data;
   endtask : reg_write
   task automatic reg_read(input logic [4:0] addr, output logic [63:0] data, output logic ok);
      @(posedge i_clock);
      #1;
      o_reg_addr = addr;
      o_reg_read = 1'b1;
      @(posedge i_clock);
      #1;
      o_reg_read = 1'b0;
      ok = i_reg_rvalid;
      data = i_reg_rdata;
   endtask : reg_read
   task automatic set_pins(input logic [2:0] pins);
      @(posedge i_clock);
      #1;
      o_profile_pins = pins;
   endtask : set_pins
   // held several cycles so the two-stage synchroniser cannot miss it
   task automatic pulse_sync;
      @(posedge i_clock);
      #1;
      o_sync_pulse = 1'b1;
      repeat (4) @(posedge i_clock);
      #1;
      o_sync_pulse = 1'b0;
   endtask : pulse_sync
endmodule : host_model
`default_nettype wire

// ### dv/test_sync_profile_ram_gpio_regs.sv
`default_nettype none
module test_sync_profile_ram_gpio_regs
   import upconv_regs_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic clock;
   logic rst_b;
   logic [4:0] reg_addr;
   logic reg_write;
   logic reg_read;
   logic [63:0] reg_wdata;
   logic [63:0] reg_rdata;
   logic reg_rvalid;
   logic [1:0] mode;
   logic [2:0] pins;
   logic sync_pulse;
   sync_fields_type sync_f;
   logic [5:0] sync_state;
   profile_out_type prof;
   logic [9:0] ram_start;
   logic [9:0] ram_end;
   logic ram_restart;
   logic ram_strobe;
   logic [9:0] ram_addr;
   logic [31:0] ram_data;
   logic [15:0] gpio_pins;
   logic [15:0] gpio_out;
   logic [15:0] gpio_oe;
   int bad_count;
   int total_checks;
   logic [41:0] ram_seen[$];
   logic [41:0] ram_exp[4];
   logic [5:0] s0;
   int n;
   profile_out_type prof_exp;

   host_model u_host (.i_clock(clock), .i_reg_rvalid(reg_rvalid), .i_reg_rdata(reg_rdata),
      .o_reg_addr(reg_addr), .o_reg_write(reg_write), .o_reg_read(reg_read),
      .o_reg_wdata(reg_wdata), .o_profile_pins(pins), .o_sync_pulse(sync_pulse));
   sync_profile_ram_gpio_regs u_dut (.i_clock(clock), .i_rst_b(rst_b), .i_reg_addr(reg_addr),
      .i_reg_write(reg_write), .i_reg_read(reg_read), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .i_operating_mode(mode),
      .i_profile_select_bit2(pins[2]), .i_profile_select_bit1(pins[1]),
      .i_profile_select_bit0(pins[0]), .i_sync_pulse(sync_pulse), .o_sync(sync_f),
      .o_sync_state(sync_state), .o_profile(prof), .i_ram_start(ram_start),
      .i_ram_end(ram_end), .i_ram_restart(ram_restart), .o_ram_wr_strobe(ram_strobe),
      .o_ram_wr_addr(ram_addr), .o_ram_wr_data(ram_data), .i_gpio_pins(gpio_pins),
      .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // strobes last one cycle, so they are collected here rather than polled
   always @(posedge clock)
      if (ram_strobe === 1'b1)
         ram_seen.push_back({ram_addr, ram_data});

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, bad_count);
   endtask : end_test
   task automatic wait_cyc(input int cycles);
      repeat (cycles) @(posedge clock);
      #1;
   endtask : wait_cyc
   task automatic read_check(input logic [4:0] addr, input logic [63:0] exp);
      logic [63:0] rd;
      logic ok;
      u_host.reg_read(addr, rd, ok);
      check(64'(ok), 64'h1);
      check(rd, exp);
   endtask : read_check
   task automatic pulse_restart;
      @(posedge clock);
      #1;
      ram_restart = 1'b1;
      @(posedge clock);
      #1;
      ram_restart = 1'b0;
   endtask : pulse_restart
   // top bits 10b so that tone mode has open bits to drop
   function automatic logic [63:0] slot_val(input int i);
      return {6'(6'h21 + i), i[1], i[0], 8'(8'hC0 + i), 16'(16'h1000 * (i + 1)),
         32'(32'h01010101 * (i + 3))};
   endfunction : slot_val
   function automatic profile_out_type exp_prof(input logic [63:0] v, input logic [1:0] m);
      profile_out_type p;
      p = '0;
      if (m != MODE_INTERP)
      begin
         p.tuning_word = v[31:0];
         p.phase_offset = v[47:32];
      end
      if (m == MODE_TONE)
         p.tone_amplitude = v[61:48];
      else
      begin
         p.interp_rate = v[63:58];
         p.output_scale = v[55:48];
         p.inverse_filter_bypass = v[56];
         if (m != MODE_INTERP)
            p.spectral_invert = v[57];
      end
      return p;
   endfunction : exp_prof

   initial
   begin
      repeat (20000) @(posedge clock);
      bad_count++;
      finish_test();
   end

   initial
   begin
      bad_count = 0;
      total_checks = 0;
      rst_b = 1'b0;
      mode = MODE_QUADRATURE_UPCONVERTER_MODE;
      ram_start = 10'h005;
      ram_end = 10'h006;
      ram_restart = 1'b0;
      gpio_pins = 16'h0000;
      ram_exp = '{{10'h005, 32'h10000000}, {10'h006, 32'h10000001},
         {10'h005, 32'h10000002}, {10'h005, 32'h20000000}};
      repeat (8) @(posedge clock);
      #1;
      rst_b = 1'b1;
      read_check(ADDR_SYNC, 64'h0);
      check(64'(sync_f), 64'h0);
      check(64'(sync_state), 64'h0);
      read_check(ADDR_SLOT_FIRST, 64'h0);
      read_check(ADDR_PIN_DIR, 64'h0);
      check(64'({gpio_out, gpio_oe}), 64'h0);
      end_test("reset values");

      u_host.reg_write(ADDR_SYNC, 64'hFFFFFFFF_A7ABB76F);
      read_check(ADDR_SYNC, 64'h00000000_A6A8B068);
      check(64'(sync_f), 64'({4'hA, 1'b0, 1'b1, 1'b1, 6'h2A, 5'h16, 5'h0D}));
      s0 = sync_state;
      wait_cyc(1);
      check(64'(sync_state), 64'(s0 + 6'h01));
      u_host.reg_write(ADDR_SYNC, 64'h08540000);
      s0 = sync_state;
      wait_cyc(3);
      check(64'(sync_state), 64'(s0));
      u_host.pulse_sync();
      n = 0;
      while (sync_state !== 6'h15 && n < 8)
      begin
         wait_cyc(1);
         n++;
      end
      check(64'(sync_state), 64'h15);
      if (sync_state !== 6'h15)
         finish_test();
      end_test("sync");

      for (int i = 0; i < 8; i++)
         u_host.reg_write(ADDR_SLOT_FIRST + 5'(i), slot_val(i));
      for (int m = 0; m < 4; m++)
      begin
         mode = 2'(m);
         for (int i = 0; i < 8; i++)
         begin
            u_host.set_pins(3'(i));
            wait_cyc(5);
            prof_exp = exp_prof(slot_val(i), 2'(m));
            check(64'(prof), 64'(prof_exp));
            check(64'(prof[77:64]), 64'(prof_exp[77:64]));
         end
      end
      read_check(ADDR_SLOT_FIRST, slot_val(0) & TONE_WMASK);
      u_host.reg_write(ADDR_SLOT_LAST, 64'hFFFFFFFFFFFFFFFF);
      read_check(ADDR_SLOT_LAST, 64'h3FFFFFFFFFFFFFFF);
      end_test("profiles");

      pulse_restart();
      for (int i = 0; i < 3; i++)
         u_host.reg_write(ADDR_RAM, {32'hFFFFFFFF, 32'h10000000 + 32'(i)});
      pulse_restart();
      u_host.reg_write(ADDR_RAM, 64'h20000000);
      wait_cyc(2);
      check(64'(ram_seen.size()), 64'h4);
      for (int i = 0; i < 4; i++)
         check(64'(ram_seen[i]), 64'(ram_exp[i]));
      end_test("ram words");

      gpio_pins = 16'hAB55;
      u_host.reg_write(ADDR_PIN_DIR, 64'h00FF);
      u_host.reg_write(ADDR_PIN_DATA, 64'hFFFF);
      wait_cyc(4);
      check(64'(gpio_oe), 64'h00FF);
      check(64'(gpio_out), 64'h00FF);
      read_check(ADDR_PIN_DATA, 64'hABFF);
      read_check(ADDR_PIN_DIR, 64'h00FF);
      read_check(5'h1F, 64'h0);
      end_test("gpio and unmapped");
      finish_test();
   end
endmodule : test_sync_profile_ram_gpio_regs
`default_nettype wire
